// *** hw/eiv_ctrl.sv ***
// External interrupt detection, vector selection and AXI4-Lite register file
// How it works
// - Every reset cause starts execution at program address 0x0000.
// - External pin vectors to 0x0001, pin-change low 0x0002, high 0x0003.
// - Watchdog 0x0004; 16-bit timer capture, compare A, B, overflow 0x0005-0x0008.
// - 8-bit timer compare A, compare B, overflow vector to 0x0009-0x000B.
// - Comparator 0x000C, converter done 0x000D, EEPROM ready 0x000E.
// - Serial start 0x000F and serial overflow 0x0010 end the table.
// - No vector is offered for a source that is not enabled.
// - Pin activity raises requests even when the pins are outputs.
// - Any masked toggle on the lower eight pins raises low group request.
// - Any masked toggle on pins 11 down to 8 raises high group request.
// - Only pins set in the two mask registers feed their group.
// - Pin changes are seen without the I/O clock for wake-up.
// - Low-level mode keeps requesting while the pin stays low.
// - Edges on the external pin are seen only while the I/O clock runs.
// - Low level on the external pin is seen without clock for wake-up.
// - Level gone before start-up ends: wake-up completes, no interrupt.
// - External request forwarded only with global and own enable set.
// - Pin sampled before edge detection; pulses of two clocks or more are caught.
// - Sense field 00 low, 01 any change, 10 falling, 11 rising.
// - External flag set on event, cleared by vector or one, zero in level mode.
// - Mask register bits 6, 5, 4 enable external, high group, low group.
// - High group flag set on masked change, cleared by vector or written one.
// - Per-pin mask bits with group enable allow that pin's requests.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps

module eiv_ctrl
	import eiv_pkg::*;
#(
	parameter int PC_N = 12
) (
	// Clock, reset, enable
	input  wire logic                         sys_clk,
	input  wire logic                         rst,
	input  wire logic                         ce,
	// AXI4-Lite write channels
	input  wire logic [7:0]                   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output      logic                         s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output      logic                         s_axi_wready,
	output      logic [1:0]                   s_axi_bresp,
	output      logic                         s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]                   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output      logic                         s_axi_arready,
	output      logic [31:0]                  s_axi_rdata,
	output      logic [1:0]                   s_axi_rresp,
	output      logic                         s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	// Pins
	input  wire logic                         ext_request_pin,
	input  wire logic [PC_N-1:0]              pin_change_inputs,
	// Core side
	input  wire logic                         globalIrqEnable,
	input  wire logic [eiv_pkg::OTHER_SRC_N-1:0] otherIrqReq,
	input  wire logic                         irqAck,
	output      eiv_pkg::eiv_vec_t            vecOut,
	output      logic [15:0]                  resetVector,
	// Clock and sleep control
	input  wire logic                         ioClkRun,
	output      logic                         wakeRequest,
	output      logic                         pullup_disable,
	output      logic                         sleep_enable,
	output      logic [1:0]                   sleepMode
);

	// Lowest set bit wins; returns all ones when no bit is set
	function automatic logic [4:0] firstSet(input logic [15:0] req);
		logic [4:0] idx;
		idx = 5'h1F;
		for (int i = 15; i >= 0; i--) begin
			if (req[i]) begin
				idx = 5'(i);
			end
		end
		return idx;
	endfunction

	localparam int SYN_N = PC_N + 1;

	// Register file state
	logic [7:0]       mcuCtl_reg;
	logic [7:0]       genMask_reg;
	logic [7:0]       pcMaskLow_reg;
	logic [7:0]       pcMaskHigh_reg;
	logic             extFlag_reg;
	logic             pcFlagLow_reg;
	logic             pcFlagHigh_reg;
	// AXI state
	logic             awHeld_reg;
	logic [7:0]       awAddr_reg;
	logic             wHeld_reg;
	logic [31:0]      wData_reg;
	logic [3:0]       wStrb_reg;
	logic             bValid_reg;
	logic [1:0]       bResp_reg;
	logic             rValid_reg;
	logic [31:0]      rData_reg;
	logic [1:0]       rResp_reg;
	// Pin sampling
	logic [SYN_N-1:0] sync1_reg;
	logic [SYN_N-1:0] sync2_reg;
	logic [SYN_N-1:0] sync3_reg;
	logic [SYN_N-1:0] filt_reg;
	logic [SYN_N-1:0] filtPrev_reg;
	eiv_vec_t         vec_reg;
	eiv_vec_t         vec_next;

	// Control fields
	wire logic [1:0]  sense     = mcuCtl_reg[SENSE_HI_BIT:SENSE_LO_BIT];
	wire logic        senseLow  = (sense == SENSE_LOW_LEVEL);
	wire logic        extEn     = genMask_reg[EXT_BIT];
	wire logic        pcEnHigh  = genMask_reg[PC_HIGH_BIT];
	wire logic        pcEnLow   = genMask_reg[PC_LOW_BIT];
	wire logic [11:0] pcMask    = {pcMaskHigh_reg[3:0], pcMaskLow_reg};

	// Filtered pin levels; bit PC_N is the external request pin
	wire logic        extLevel  = filt_reg[PC_N];
	wire logic        extRise   = filt_reg[PC_N] & ~filtPrev_reg[PC_N];
	wire logic        extFall   = ~filt_reg[PC_N] & filtPrev_reg[PC_N];
	// pin inputs are read whatever their port direction
	wire logic [11:0] pcToggle  = filt_reg[PC_N-1:0] ^ filtPrev_reg[PC_N-1:0];

	// only masked pins contribute to either group
	// per-pin mask bits gate each change
	wire logic [11:0] pcHit     = pcToggle & pcMask;
	wire logic        pcSetLow  = |pcHit[7:0];
	wire logic        pcSetHigh = |pcHit[11:8];

	// edges only counted while the I/O clock runs
	wire logic        extEdgeEv = ioClkRun & ((sense == SENSE_ANY_EDGE) & (extRise | extFall)
		| (sense == SENSE_FALLING) & extFall
		| (sense == SENSE_RISING) & extRise);

	// AXI decode
	wire logic        awTake    = s_axi_awvalid & s_axi_awready;
	wire logic        wTake     = s_axi_wvalid & s_axi_wready;
	wire logic        doWrite   = awHeld_reg & wHeld_reg;
	wire logic [5:0]  wIdx      = awAddr_reg[7:2];
	wire logic        wLane0    = doWrite & wStrb_reg[0];
	wire logic [7:0]  wByte     = wData_reg[7:0];
	wire logic        wrCtl     = wLane0 & (wIdx == MCU_CONTROL_IDX);
	wire logic        wrMask    = wLane0 & (wIdx == GEN_IRQ_MASK_IDX);
	wire logic        wrFlag    = wLane0 & (wIdx == GEN_IRQ_FLAG_IDX);
	wire logic        wrPcHigh  = wLane0 & (wIdx == PC_MASK_HIGH_IDX);
	wire logic        wrPcLow   = wLane0 & (wIdx == PC_MASK_LOW_IDX);
	wire logic        wMapped   = (wIdx == MCU_CONTROL_IDX) | (wIdx == GEN_IRQ_MASK_IDX)
		| (wIdx == GEN_IRQ_FLAG_IDX) | (wIdx == PC_MASK_HIGH_IDX) | (wIdx == PC_MASK_LOW_IDX);
	wire logic        arTake    = s_axi_arvalid & s_axi_arready;
	wire logic [5:0]  rIdx      = s_axi_araddr[7:2];

	// Flag clears: written one or vector taken by the core
	wire logic        ackExt    = irqAck & vec_reg.valid & (vec_reg.addr == VEC_EXT);
	wire logic        ackPcLow  = irqAck & vec_reg.valid & (vec_reg.addr == VEC_PC_LOW);
	wire logic        ackPcHigh = irqAck & vec_reg.valid & (vec_reg.addr == VEC_PC_HIGH);
	wire logic        clrExt    = ackExt | wrFlag & wByte[EXT_BIT];
	wire logic        clrPcLow  = ackPcLow | wrFlag & wByte[PC_LOW_BIT];
	wire logic        clrPcHigh = ackPcHigh | wrFlag & wByte[PC_HIGH_BIT];

	// set wins over clear; level mode holds the flag at zero
	wire logic        extFlag_next    = ~senseLow & (extEdgeEv | extFlag_reg & ~clrExt);
	// high group flag set beats a same-cycle clear
	wire logic        pcFlagHigh_next = pcSetHigh | pcFlagHigh_reg & ~clrPcHigh;
	wire logic        pcFlagLow_next  = pcSetLow | pcFlagLow_reg & ~clrPcLow;

	// level mode requests for as long as the pin reads low
	// a level gone by start-up end leaves no request behind
	wire logic        extReq    = extEn & (senseLow ? ~extLevel : extFlag_reg);
	// global and own enable both needed
	// disabled sources never reach the vector
	wire logic [15:0] reqVec    = {globalIrqEnable ? {otherIrqReq,
		pcEnHigh & pcFlagHigh_reg, pcEnLow & pcFlagLow_reg, extReq} : 16'h0000};
	wire logic [4:0]  winIdx    = firstSet(reqVec);

	// Vector selection; lowest table position has priority
	// external and pin-change vectors follow reset in order
	// watchdog and timer vectors follow from 0x0004
	// 8-bit timer sources keep their table slots
	// serial slots end at the last vector
	always_comb begin
		vec_next.valid = (winIdx != 5'h1F);
		vec_next.addr  = vec_next.valid ? VEC_EXT + 16'(winIdx) : VEC_RESET;
	end

	// one reset entry for every reset cause
	assign resetVector = VEC_RESET;

	// async pin-change wake compares raw pins to the held level
	// async low level wake in level mode, no clock needed
	assign wakeRequest = (|((pin_change_inputs ^ filt_reg[PC_N-1:0]) & pcMask
		& {{4{pcEnHigh}}, {8{pcEnLow}}})) | extEn & senseLow & ~ext_request_pin;

	// Bus handshakes are combinational from held state
	assign s_axi_awready = ~awHeld_reg & ~bValid_reg;
	assign s_axi_wready  = ~wHeld_reg & ~bValid_reg;
	assign s_axi_bvalid  = bValid_reg;
	assign s_axi_bresp   = bResp_reg;
	assign s_axi_arready = ~rValid_reg;
	assign s_axi_rvalid  = rValid_reg;
	assign s_axi_rdata   = rData_reg;
	assign s_axi_rresp   = rResp_reg;
	assign vecOut        = vec_reg;

	// Control outputs straight from the control register
	assign pullup_disable = mcuCtl_reg[PULLUP_DISABLE_BIT];
	assign sleep_enable   = mcuCtl_reg[SLEEP_ENABLE_BIT];
	assign sleepMode      = mcuCtl_reg[SLEEP_MODE_HI_BIT:SLEEP_MODE_LO_BIT];

	// Read mux; reserved bits and unmapped words read zero
	wire logic [7:0]  rByte =
		(rIdx == MCU_CONTROL_IDX)  ? mcuCtl_reg :
		(rIdx == GEN_IRQ_MASK_IDX) ? genMask_reg :
		(rIdx == GEN_IRQ_FLAG_IDX) ? {1'b0, extFlag_reg, pcFlagHigh_reg, pcFlagLow_reg, 4'h0} :
		(rIdx == PC_MASK_HIGH_IDX) ? pcMaskHigh_reg :
		(rIdx == PC_MASK_LOW_IDX)  ? pcMaskLow_reg : 8'h00;
	wire logic        rMapped = (rIdx == MCU_CONTROL_IDX) | (rIdx == GEN_IRQ_MASK_IDX)
		| (rIdx == GEN_IRQ_FLAG_IDX) | (rIdx == PC_MASK_HIGH_IDX) | (rIdx == PC_MASK_LOW_IDX);

	// three-stage sampling; a change counts once stages two and three agree
	// the filtered level feeds edge detection, so a pulse must last two clocks to be caught
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1_reg    <= '0;
			sync2_reg    <= '0;
			sync3_reg    <= '0;
			filt_reg     <= '0;
			filtPrev_reg <= '0;
		end else if (ce) begin
			sync1_reg    <= {ext_request_pin, pin_change_inputs};
			sync2_reg    <= sync1_reg;
			sync3_reg    <= sync2_reg;
			filt_reg     <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));
			filtPrev_reg <= filt_reg;
		end
	end

	// enable bits 6..4, others read zero
	// Registers and flags; bus writes land one cycle after both halves are held
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mcuCtl_reg     <= MCU_CONTROL_RST;
			genMask_reg    <= GEN_IRQ_MASK_RST;
			pcMaskLow_reg  <= PC_MASK_LOW_RST;
			pcMaskHigh_reg <= PC_MASK_HIGH_RST;
			extFlag_reg    <= 1'b0;
			pcFlagLow_reg  <= 1'b0;
			pcFlagHigh_reg <= 1'b0;
			vec_reg        <= '0;
		end else if (ce) begin
			if (wrCtl) begin
				mcuCtl_reg <= wByte & MCU_CONTROL_WMASK;
			end
			if (wrMask) begin
				genMask_reg <= wByte & 8'h70;
			end
			if (wrPcLow) begin
				pcMaskLow_reg <= wByte;
			end
			if (wrPcHigh) begin
				pcMaskHigh_reg <= wByte & PC_MASK_HIGH_WMASK;
			end
			extFlag_reg    <= extFlag_next;
			pcFlagLow_reg  <= pcFlagLow_next;
			pcFlagHigh_reg <= pcFlagHigh_next;
			vec_reg        <= vec_next;
		end
	end

	// AXI write side; address and data may arrive in either order
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			awHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wHeld_reg  <= 1'b0;
			wData_reg  <= 32'h0000_0000;
			wStrb_reg  <= 4'h0;
			bValid_reg <= 1'b0;
			bResp_reg  <= AXI_OKAY;
		end else if (ce) begin
			if (awTake) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (wTake) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_reg <= 1'b0;
				wHeld_reg  <= 1'b0;
				bValid_reg <= 1'b1;
				bResp_reg  <= wMapped ? AXI_OKAY : AXI_SLVERR;
			end else if (bValid_reg & s_axi_bready) begin
				bValid_reg <= 1'b0;
			end
		end
	end

	// AXI read side; one outstanding read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rValid_reg <= 1'b0;
			rData_reg  <= 32'h0000_0000;
			rResp_reg  <= AXI_OKAY;
		end else if (ce) begin
			if (arTake) begin
				rValid_reg <= 1'b1;
				rData_reg  <= {24'h00_0000, rByte};
				rResp_reg  <= rMapped ? AXI_OKAY : AXI_SLVERR;
			end else if (rValid_reg & s_axi_rready) begin
				rValid_reg <= 1'b0;
			end
		end
	end

	// Checks on the detection and vector logic
	a_level_flag_zero: assert property (@(posedge sys_clk) disable iff (rst)
		ce && senseLow |=> !extFlag_reg)
		else $error("external flag set in level mode");

	a_rise_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
		ce && ioClkRun && sense == SENSE_RISING && extRise |=> extFlag_reg)
		else $error("rising edge did not set external flag");

	a_edge_needs_clk: assert property (@(posedge sys_clk) disable iff (rst)
		ce && !ioClkRun && !extFlag_reg |=> !extFlag_reg)
		else $error("edge flagged while I/O clock stopped");

	a_mask_blocks_low: assert property (@(posedge sys_clk) disable iff (rst)
		ce && !pcFlagLow_reg && (pcToggle[7:0] & pcMaskLow_reg) == 8'h00 |=> !pcFlagLow_reg)
		else $error("unmasked pin set low group flag");

	a_high_group_set: assert property (@(posedge sys_clk) disable iff (rst)
		ce && (pcToggle[11:8] & pcMaskHigh_reg[3:0]) != 4'h0 |=> pcFlagHigh_reg)
		else $error("masked upper toggle lost");

	a_level_holds_req: assert property (@(posedge sys_clk) disable iff (rst)
		ce && globalIrqEnable && extEn && senseLow && !extLevel
		|=> vec_reg.valid && vec_reg.addr == VEC_EXT)
		else $error("held low level not offered as vector");

	a_gated_vector: assert property (@(posedge sys_clk) disable iff (rst)
		ce && !globalIrqEnable |=> !vec_reg.valid)
		else $error("vector offered with global enable clear");

	a_filter_agree: assert property (@(posedge sys_clk) disable iff (rst)
		ce && $past(ce) && filt_reg != $past(filt_reg)
		|-> ((($past(sync2_reg) ^ $past(sync3_reg)) & (filt_reg ^ $past(filt_reg))) == '0))
		else $error("filtered level changed without stage agreement");

	a_wake_low_level: assert property (@(posedge sys_clk) disable iff (rst)
		extEn && senseLow && !ext_request_pin |-> wakeRequest)
		else $error("low level did not request wake-up");

	a_bresp_holds: assert property (@(posedge sys_clk) disable iff (rst)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before taken");

	// Main scenarios
	c_ext_vector: cover property (@(posedge sys_clk) vec_reg.valid && vec_reg.addr == VEC_EXT);
	c_pc_high_ack: cover property (@(posedge sys_clk) ackPcHigh);
	c_set_and_clear: cover property (@(posedge sys_clk) pcSetLow && clrPcLow);
	c_last_vector: cover property (@(posedge sys_clk) vec_reg.valid && vec_reg.addr == VEC_LAST);

endmodule

// *** hw/eiv_pkg.sv ***
// Package of constants and types for the external interrupt and vector block
package eiv_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [5:0] MCU_CONTROL_IDX   = 6'h35;
	localparam logic [5:0] GEN_IRQ_MASK_IDX  = 6'h3B;
	localparam logic [5:0] GEN_IRQ_FLAG_IDX  = 6'h3A;
	localparam logic [5:0] PC_MASK_HIGH_IDX  = 6'h20;
	localparam logic [5:0] PC_MASK_LOW_IDX   = 6'h12;

	// Reset values
	localparam logic [7:0] MCU_CONTROL_RST   = 8'h00;
	localparam logic [7:0] GEN_IRQ_MASK_RST  = 8'h00;
	localparam logic [7:0] PC_MASK_HIGH_RST  = 8'h00;
	localparam logic [7:0] PC_MASK_LOW_RST   = 8'h00;

	// Writable bits of the control and mask registers
	localparam logic [7:0] MCU_CONTROL_WMASK = 8'h7B;
	localparam logic [7:0] PC_MASK_HIGH_WMASK = 8'h0F;

	// Field positions
	localparam int PULLUP_DISABLE_BIT = 6;
	localparam int SLEEP_ENABLE_BIT   = 5;
	localparam int SLEEP_MODE_HI_BIT  = 4;
	localparam int SLEEP_MODE_LO_BIT  = 3;
	localparam int SENSE_HI_BIT       = 1;
	localparam int SENSE_LO_BIT       = 0;
	localparam int EXT_BIT            = 6;
	localparam int PC_HIGH_BIT        = 5;
	localparam int PC_LOW_BIT         = 4;

	// Sense control encodings
	localparam logic [1:0] SENSE_LOW_LEVEL = 2'b00;
	localparam logic [1:0] SENSE_ANY_EDGE  = 2'b01;
	localparam logic [1:0] SENSE_FALLING   = 2'b10;
	localparam logic [1:0] SENSE_RISING    = 2'b11;

	// Vector program addresses
	localparam logic [15:0] VEC_RESET     = 16'h0000;
	localparam logic [15:0] VEC_EXT       = 16'h0001;
	localparam logic [15:0] VEC_PC_LOW    = 16'h0002;
	localparam logic [15:0] VEC_PC_HIGH   = 16'h0003;
	localparam logic [15:0] VEC_WATCHDOG  = 16'h0004;
	localparam logic [15:0] VEC_LAST      = 16'h0010;

	// Sources beyond the external ones, watchdog upward
	localparam int OTHER_SRC_N = 13;

	// AXI responses
	localparam logic [1:0] AXI_OKAY   = 2'b00;
	localparam logic [1:0] AXI_SLVERR = 2'b10;

	// Vector offered to the core
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} eiv_vec_t;

endpackage

// *** sim/eiv_core_model.sv ***
// Core model: fetches vectored requests and acknowledges them
`timescale 1ns/1ps

module eiv_core_model
	import eiv_pkg::*;
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// Vector fetch side
	input  wire eiv_pkg::eiv_vec_t vecIn,
	input  wire logic              ackEn,
	input  wire logic [3:0]        ackDelay,
	output      logic              irqAck,
	output      logic [15:0]       takenAddr,
	output      int                takenCount
);
	import eiv_pkg::*;

	logic [3:0] waitCnt;
	logic       ackDly;

	// Take after ackDelay cycles; the vector is stale for two cycles after an ack
	always @(posedge sys_clk) begin
		ackDly <= irqAck;
		irqAck <= 1'h0;
		if (rst) begin
			waitCnt    <= 4'h0;
			takenCount <= 0;
			takenAddr  <= 16'h0000;
		end else if (irqAck || ackDly || !vecIn.valid || !ackEn) begin
			waitCnt <= 4'h0;
		end else if (waitCnt >= ackDelay) begin
			irqAck     <= 1'h1;
			takenAddr  <= vecIn.addr;
			takenCount <= takenCount + 1;
			waitCnt    <= 4'h0;
		end else begin
			waitCnt <= waitCnt + 4'h1;
		end
	end
endmodule

// *** sim/tb_external_interrupt_vectors.sv ***
// Self-checking bench for the external interrupt and vector block
`timescale 1ns/1ps

module tb_external_interrupt_vectors;
	import eiv_pkg::*;

	localparam logic [7:0] aMcu = {MCU_CONTROL_IDX, 2'h0};
	localparam logic [7:0] aMsk = {GEN_IRQ_MASK_IDX, 2'h0};
	localparam logic [7:0] aFlg = {GEN_IRQ_FLAG_IDX, 2'h0};
	localparam logic [7:0] aPcH = {PC_MASK_HIGH_IDX, 2'h0};
	localparam logic [7:0] aPcL = {PC_MASK_LOW_IDX, 2'h0};

	logic        sys_clk, rst, awValid, awReady, wValid, wReady, bValid, bReady;
	logic        arValid, arReady, rValid, rReady, extPin, gie, irqAck, ioRun, wake;
	logic        pullupDisable, sleepEnable, ackEn, ce;
	logic [7:0]  awAddr, arAddr;
	logic [31:0] wData, rData;
	logic [1:0]  bResp, rResp, sleepMode;
	logic [11:0] pcIn;
	logic [12:0] otherReq;
	logic [15:0] resetVec, takenAddr;
	logic [3:0]  ackDelay;
	eiv_vec_t    vecOut;
	int          takenCount, errors, samplesChecked;

	eiv_ctrl eiv_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady), .ext_request_pin(extPin),
		.pin_change_inputs(pcIn), .globalIrqEnable(gie), .otherIrqReq(otherReq),
		.irqAck(irqAck), .vecOut(vecOut), .resetVector(resetVec), .ioClkRun(ioRun),
		.wakeRequest(wake), .pullup_disable(pullupDisable),
		.sleep_enable(sleepEnable), .sleepMode(sleepMode));

	eiv_core_model eiv_core_model_inst (.sys_clk(sys_clk), .rst(rst), .vecIn(vecOut),
		.ackEn(ackEn), .ackDelay(ackDelay), .irqAck(irqAck), .takenAddr(takenAddr),
		.takenCount(takenCount));

	// Free-running 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samplesChecked, errors);
		if (errors == 0 && samplesChecked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samplesChecked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bus write: hold each channel until its own handshake, wait bounded for bvalid
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		@(posedge sys_clk);
		awAddr  <= a;
		wData   <= {24'h00_0000, d};
		awValid <= 1'h1;
		wValid  <= 1'h1;
		bReady  <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			if (awValid && awReady) awValid <= 1'h0;
			if (wValid && wReady) wValid <= 1'h0;
			if (bValid) break;
		end
		bReady <= 1'h0;
		chk("bresp", er, bResp);
		if (n == 40) begin
			errors++;
			tally_and_finish();
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge sys_clk);
		arAddr  <= a;
		arValid <= 1'h1;
		rReady  <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			if (arValid && arReady) arValid <= 1'h0;
			if (rValid) break;
		end
		rReady <= 1'h0;
		chk("rdata", ed, rData);
		chk("rresp", er, rResp);
		if (n == 40) begin
			errors++;
			tally_and_finish();
		end
	endtask

	// Pin level held four cycles, well over one clock period
	task automatic pin(input logic v);
		@(posedge sys_clk);
		extPin <= v;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic pc(input int i);
		@(posedge sys_clk);
		pcIn[i] <= ~pcIn[i];
		repeat (4) @(posedge sys_clk);
	endtask

	// Bounded wait for the core model to take a vector
	task automatic expect_vec(input logic [15:0] ea, input logic want);
		int c0;
		c0 = takenCount;
		for (int n = 0; n < 16 && takenCount == c0; n++) @(posedge sys_clk);
		chk("vecTaken", want, takenCount != c0);
		if (want) chk("vecAddr", ea, takenAddr);
		if (want && takenCount == c0) tally_and_finish();
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic t_reset();
		chk("resetVector", 16'h0000, resetVec);
		axi_rd(aMcu, 0, AXI_OKAY);
		axi_rd(aMsk, 0, AXI_OKAY);
		chk("vecValid", 0, vecOut.valid);
		$display("test reset done");
	endtask

	task automatic t_regs();
		axi_wr(aMcu, 8'hFF, AXI_OKAY);
		axi_rd(aMcu, 32'h0000_007B, AXI_OKAY);
		chk("mcuFields", 4'hF, {pullupDisable, sleepEnable, sleepMode});
		axi_wr(aMcu, 8'h00, AXI_OKAY);
		axi_wr(aMsk, 8'hFF, AXI_OKAY);
		axi_rd(aMsk, 32'h0000_0070, AXI_OKAY);
		axi_wr(aMsk, 8'h00, AXI_OKAY);
		axi_wr(aPcH, 8'hFF, AXI_OKAY);
		axi_rd(aPcH, 32'h0000_000F, AXI_OKAY);
		axi_wr(8'h04, 8'h55, AXI_SLVERR);
		axi_rd(8'h04, 0, AXI_SLVERR);
		$display("test registers done");
	endtask

	task automatic t_pinchange();
		axi_wr(aPcH, 8'h08, AXI_OKAY);
		axi_wr(aPcL, 8'h01, AXI_OKAY);
		axi_wr(aMsk, 8'h10, AXI_OKAY);
		pc(1);
		expect_vec(VEC_PC_LOW, 0);
		@(posedge sys_clk);
		pcIn[0] <= ~pcIn[0];
		@(negedge sys_clk);
		chk("wakePc", 1, wake);
		expect_vec(VEC_PC_LOW, 1);
		axi_wr(aMsk, 8'h30, AXI_OKAY);
		pc(11);
		expect_vec(VEC_PC_HIGH, 1);
		ackEn <= 1'h0;
		pc(11);
		axi_rd(aFlg, 32'h0000_0020, AXI_OKAY);
		axi_wr(aFlg, 8'h20, AXI_OKAY);
		axi_rd(aFlg, 0, AXI_OKAY);
		ackEn <= 1'h1;
		axi_wr(aMsk, 8'h00, AXI_OKAY);
		pc(0);
		expect_vec(VEC_PC_LOW, 0);
		axi_wr(aFlg, 8'h70, AXI_OKAY);
		$display("test pin change done");
	endtask

	task automatic t_level();
		axi_wr(aMsk, 8'h40, AXI_OKAY);
		pin(1'h0);
		expect_vec(VEC_EXT, 1);
		expect_vec(VEC_EXT, 1);
		chk("wakeLevel", 1, wake);
		axi_rd(aFlg, 0, AXI_OKAY);
		pin(1'h1);
		repeat (8) @(posedge sys_clk);
		chk("vecValid", 0, vecOut.valid);
		gie <= 1'h0;
		pin(1'h0);
		expect_vec(VEC_EXT, 0);
		pin(1'h1);
		gie <= 1'h1;
		expect_vec(VEC_EXT, 0);
		$display("test level done");
	endtask

	// Clock enable low freezes detection; the async wake path still answers
	task automatic t_freeze();
		axi_wr(aMsk, 8'h10, AXI_OKAY);
		ce <= 1'h0;
		pc(0);
		chk("wakeFrozen", 1, wake);
		expect_vec(VEC_PC_LOW, 0);
		ce <= 1'h1;
		expect_vec(VEC_PC_LOW, 1);
		axi_wr(aMsk, 8'h00, AXI_OKAY);
		$display("test freeze done");
	endtask

	task automatic t_edges();
		for (int code = 1; code < 4; code++) begin
			ackDelay <= 4'(code);
			axi_wr(aMcu, 8'(code), AXI_OKAY);
			pin(1'h0);
			expect_vec(VEC_EXT, code != 3);
			pin(1'h1);
			expect_vec(VEC_EXT, code != 2);
		end
		ackDelay <= 4'h0;
		axi_wr(aMcu, 8'h01, AXI_OKAY);
		ioRun <= 1'h0;
		pin(1'h0);
		pin(1'h1);
		repeat (4) @(posedge sys_clk);
		ioRun <= 1'h1;
		expect_vec(VEC_EXT, 0);
		ackEn <= 1'h0;
		axi_wr(aMsk, 8'h00, AXI_OKAY);
		axi_wr(aMcu, 8'h03, AXI_OKAY);
		pin(1'h0);
		pin(1'h1);
		repeat (4) @(posedge sys_clk);
		axi_rd(aFlg, 32'h0000_0040, AXI_OKAY);
		axi_wr(aFlg, 8'h40, AXI_OKAY);
		axi_rd(aFlg, 0, AXI_OKAY);
		ackEn <= 1'h1;
		$display("test edges done");
	endtask

	task automatic t_other();
		for (int i = 0; i < 13; i++) begin
			otherReq <= 13'h0001 << i;
			expect_vec(VEC_WATCHDOG + 16'(i), 1);
			otherReq <= 13'h0000;
			repeat (4) @(posedge sys_clk);
		end
		$display("test other sources done");
	endtask

	initial begin
		sys_clk = 1'h0;
		rst = 1'h1;
		{awValid, wValid, bReady, arValid, rReady} = 5'h00;
		{awAddr, arAddr, wData} = 48'h0000_0000_0000;
		extPin = 1'h1;
		pcIn = 12'h000;
		otherReq = 13'h0000;
		{gie, ioRun, ackEn, ce} = 4'hF;
		ackDelay = 4'h0;
		errors = 0;
		samplesChecked = 0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'h0;
		repeat (8) @(posedge sys_clk);
		t_reset();
		t_regs();
		t_pinchange();
		t_level();
		t_edges();
		t_other();
		t_freeze();
		tally_and_finish();
	end
endmodule
